// *** hdl/ipv_map.svh ***
// Register offsets, field positions, reset values and vectors of the interrupt controller.
// How it works
// - A peripheral flag requests only with global mask clear and its enable set.
// - A blocked flag stays latched and pending instead of being dropped.
// - Writing zero to a flag bit in the status register clears it.
// - Status read with flag set, then associated register access, clears the flag.
// - A clearing sequence drops the latch, losing a request still waiting for enable.
// - Wakeup and external lines vector to FFFA, FFF8, FFF6, FFF4, FFF0, FFEE.
// - Timer output compare vectors to FFEA and never wakes from halt.
// - Timer overflow vectors to FFE8 and may leave timed halt.
// - Light timer capture at FFE6, tick at FFE4; these two are lowest priority.
// - Timer overflow and tick leave timed halt only, never plain halt.
// - The wakeup unit interrupt at FFFA leaves only wakeup halt mode.
// - A falling edge on line one never wakes from any halt mode.
// - Sensitivity fields: bits 5:4 line two, 3:2 line one, 1:0 line zero.
// - All eight sensitivity bits are writable only while global mask is set.
// - Changing a line's sensitivity clears that line's pending request.
// - Codes: 00 falling plus low, 01 rising, 10 falling, 11 both edges.
// - The sensitivity register resets to zero on every line.
// - Among pending requests the lowest slot number is serviced first.
// - A latched external edge request clears when its service is entered.
// - Entering any service sets the global mask so no slot request nests; a trap ignores the mask and still can.
`ifndef IPV_MAP_SVH
`define IPV_MAP_SVH

`define IPV_ADDR_PSTAT 12'h000
`define IPV_ADDR_PEN 12'h004
`define IPV_ADDR_ASSOC 12'h008
`define IPV_SENSE_INDEX 12'h037
`define IPV_ADDR_SENSE 12'h0DC
`define IPV_SENSE_RESET 8'h00
`define IPV_FLAGS_RESET 5'h00

`define IPV_PB_AWU 0
`define IPV_PB_ATOC 1
`define IPV_PB_ATOVF 2
`define IPV_PB_LTIC 3
`define IPV_PB_LTRTC 4

`define IPV_SENSE_FALL_LOW 2'h0
`define IPV_SENSE_RISE 2'h1
`define IPV_SENSE_FALL 2'h2
`define IPV_SENSE_BOTH 2'h3

`define IPV_SLOTS 14
`define IPV_SLOT_AWU 4'h0
`define IPV_SLOT_EXT0 4'h1
`define IPV_SLOT_EXT1 4'h2
`define IPV_SLOT_EXT2 4'h3
`define IPV_SLOT_EXT3 4'h5
`define IPV_SLOT_EXT4 4'h6
`define IPV_SLOT_ATOC 4'h8
`define IPV_SLOT_ATOVF 4'h9
`define IPV_SLOT_LTIC 4'hA
`define IPV_SLOT_LTRTC 4'hB

`define IPV_VEC_RESET 16'hFFFE
`define IPV_VEC_TRAP 16'hFFFC
`define IPV_VEC_SLOT0 16'hFFFA

`endif

// *** hdl/ipv_pkg.sv ***
// Types shared by the interrupt controller modules.
package ipv_pkg;

    typedef enum logic [1:0] {
        IPV_RUN,
        IPV_HALT,
        IPV_TIMED_HALT,
        IPV_AWU_HALT
    } ipv_power_type;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [7:0] sense;
        logic [4:0] flag;
        logic [4:0] enable;
        logic [4:0] clrArm;
        logic [4:0] extPend;
        logic [4:0] extPrev;
        logic trapPend;
        logic intReq;
        logic isTrap;
        logic [3:0] slot;
        logic [15:0] vector;
        logic setMask;
        logic wakeUp;
    } ipv_state_type;

endpackage : ipv_pkg

// *** hdl/ipv_sync.sv ***
// Two-stage synchroniser for the external interrupt pins.
`timescale 1ns/10ps
module ipv_sync #(
    parameter int WIDTH = 5
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } ipv_sync_type;

    ipv_sync_type state_q;
    ipv_sync_type state_d;

    always_comb begin
        state_d = state_q;
        state_d.meta = din;
        state_d.stable = state_q.meta;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= '{default: '1};
        end else if (ce) begin
            state_q <= state_d;
        end
    end

    assign dout = state_q.stable;

endmodule : ipv_sync

// *** hdl/ipv_prio.sv ***
// Fixed priority picker: the lowest requesting slot wins.
`timescale 1ns/10ps
module ipv_prio #(
    parameter int SLOTS = 14
) (
    input wire logic [SLOTS-1:0] req,
    output logic valid,
    output logic [3:0] idx
);

    always_comb begin
        valid = 1'b0;
        idx = 4'h0;
        for (int i = SLOTS - 1; i >= 0; i--) begin
            if (req[i]) begin
                valid = 1'b1;
                idx = 4'(i);
            end
        end
    end

endmodule : ipv_prio

// *** hdl/ipv_ctrl.sv ***
// Interrupt controller top: flags, sensitivity, priority, vectors and halt wakeup.
`timescale 1ns/10ps
`include "ipv_map.svh"
module ipv_ctrl
    import ipv_pkg::*;
#(
    parameter logic [1:0] LINE_THREE_SENSE = `IPV_SENSE_FALL_LOW,
    parameter logic [1:0] LINE_FOUR_SENSE = `IPV_SENSE_FALL_LOW
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [4:0] extLine,
    input wire logic [4:0] periphEvent,
    input wire logic globalMask,
    input wire logic trapReq,
    input wire logic intAck,
    input wire ipv_power_type powerMode,
    output logic intReq,
    output logic [15:0] intVector,
    output logic setGlobalMask,
    output logic wakeUp
);

    ipv_state_type state_q;
    ipv_state_type state_d;

    logic [4:0] lineLevel;
    logic [4:0] lineRise;
    logic [4:0] lineFall;
    logic [4:0] edgeHit;
    logic [4:0] lowHit;
    logic [4:0] extReq;
    logic [4:0] periphReq;
    logic [`IPV_SLOTS-1:0] slotReq;
    logic prioValid;
    logic [3:0] prioIdx;
    logic apbDone;
    logic apbWrite;
    logic apbRead;
    logic lineOneRiseWake;

    ipv_sync #(
        .WIDTH(5)
    ) u_sync (
        .clk(clk),
        .reset_n(reset_n),
        .ce(ce),
        .din(extLine),
        .dout(lineLevel)
    );

    assign lineRise = lineLevel & ~state_q.extPrev;
    assign lineFall = ~lineLevel & state_q.extPrev;

    // Per-line sensitivity decode: edge latch sets and low level requests.
    genvar g;
    generate
        for (g = 0; g < 5; g++) begin : g_line
            logic [1:0] sense;
            logic hit;
            if (g < 3) begin : g_reg
                assign sense = state_q.sense[2*g+1:2*g];
            end else if (g == 3) begin : g_three
                assign sense = LINE_THREE_SENSE;
            end else begin : g_four
                assign sense = LINE_FOUR_SENSE;
            end
            always_comb begin
                unique case (sense)
                    `IPV_SENSE_FALL_LOW: hit = lineFall[g];
                    `IPV_SENSE_RISE: hit = lineRise[g];
                    `IPV_SENSE_FALL: hit = lineFall[g];
                    `IPV_SENSE_BOTH: hit = lineRise[g] | lineFall[g];
                endcase
            end
            // Each line's edge hit has one driver, its own bit.
            assign edgeHit[g] = hit;
            assign lowHit[g] = (sense == `IPV_SENSE_FALL_LOW) & ~lineLevel[g];
            assign extReq[g] = state_q.extPend[g] | lowHit[g];
        end
    endgenerate

    // Line one wakes only on a rising edge it is sensitive to.
    assign lineOneRiseWake = lineRise[1] & state_q.sense[2];

    assign periphReq = state_q.flag & state_q.enable;

    // Slot map; unused slots are tied low yet keep their priority position.
    assign slotReq = {
        2'b00,
        periphReq[`IPV_PB_LTRTC],
        periphReq[`IPV_PB_LTIC],
        periphReq[`IPV_PB_ATOVF],
        periphReq[`IPV_PB_ATOC],
        1'b0,
        extReq[4],
        extReq[3],
        1'b0,
        extReq[2],
        extReq[1],
        extReq[0],
        periphReq[`IPV_PB_AWU]
    };

    ipv_prio #(
        .SLOTS(`IPV_SLOTS)
    ) u_prio (
        .req(slotReq),
        .valid(prioValid),
        .idx(prioIdx)
    );

    assign apbDone = psel & penable & state_q.pready;
    assign apbWrite = apbDone & pwrite;
    assign apbRead = apbDone & ~pwrite;

    always_comb begin
        logic [4:0] flagClr;
        logic [4:0] extClr;
        logic [7:0] newSense;
        logic mapped;
        logic wakeCond;
        flagClr = 5'h00;
        extClr = 5'h00;
        newSense = pwdata[7:0];
        mapped = 1'b0;
        wakeCond = 1'b0;
        state_d = state_q;
        state_d.extPrev = lineLevel;
        state_d.setMask = 1'b0;

        // Bus slave: one wait state, then the transfer completes with pready.
        state_d.pready = 1'b0;
        if (psel && penable && !state_q.pready) begin
            state_d.pready = 1'b1;
            state_d.prdata = 32'h0000_0000;
            unique case (paddr)
                `IPV_ADDR_PSTAT: begin
                    mapped = 1'b1;
                    state_d.prdata[4:0] = state_q.flag;
                end
                `IPV_ADDR_PEN: begin
                    mapped = 1'b1;
                    state_d.prdata[4:0] = state_q.enable;
                end
                `IPV_ADDR_ASSOC: begin
                    mapped = 1'b1;
                    state_d.prdata[4:0] = state_q.extPend;
                end
                `IPV_ADDR_SENSE: begin
                    mapped = 1'b1;
                    state_d.prdata[7:0] = state_q.sense;
                end
                default: mapped = 1'b0;
            endcase
            state_d.pslverr = ~mapped;
        end else if (!psel) begin
            state_d.pslverr = 1'b0;
        end

        if (apbWrite && paddr == `IPV_ADDR_PSTAT) begin
            flagClr = ~pwdata[4:0];
        end
        if (apbWrite && paddr == `IPV_ADDR_PEN) begin
            state_d.enable = pwdata[4:0];
        end
        if (apbRead && paddr == `IPV_ADDR_PSTAT) begin
            state_d.clrArm = state_q.flag;
        end
        if (apbDone && paddr == `IPV_ADDR_ASSOC) begin
            flagClr = flagClr | state_q.clrArm;
            state_d.clrArm = 5'h00;
        end
        if (apbWrite && paddr == `IPV_ADDR_SENSE && globalMask) begin
            state_d.sense = newSense;
            for (int i = 0; i < 3; i++) begin
                if (newSense[2*i+:2] != state_q.sense[2*i+:2]) begin
                    extClr[i] = 1'b1;
                end
            end
        end

        // Clearing drops the latch even if the source was never enabled.
        state_d.flag = (state_q.flag & ~flagClr) | periphEvent;

        // Service entry, trap and request presentation.
        if (trapReq) begin
            state_d.trapPend = 1'b1;
        end
        if (intAck && state_q.intReq) begin
            state_d.intReq = 1'b0;
            state_d.setMask = 1'b1;
            if (state_q.isTrap) begin
                state_d.trapPend = trapReq;
            end else begin
                unique case (state_q.slot)
                    `IPV_SLOT_EXT0: extClr[0] = 1'b1;
                    `IPV_SLOT_EXT1: extClr[1] = 1'b1;
                    `IPV_SLOT_EXT2: extClr[2] = 1'b1;
                    `IPV_SLOT_EXT3: extClr[3] = 1'b1;
                    `IPV_SLOT_EXT4: extClr[4] = 1'b1;
                    default: extClr = extClr;
                endcase
            end
        end else if (state_q.setMask) begin
            state_d.intReq = 1'b0;
        end else if (state_q.trapPend) begin
            state_d.intReq = 1'b1;
            state_d.isTrap = 1'b1;
            state_d.vector = `IPV_VEC_TRAP;
        end else if (!globalMask && prioValid) begin
            state_d.intReq = 1'b1;
            state_d.isTrap = 1'b0;
            state_d.slot = prioIdx;
            state_d.vector = `IPV_VEC_SLOT0 - {11'h000, prioIdx, 1'b0};
        end else begin
            state_d.intReq = 1'b0;
        end

        // A new edge in the same cycle as a clear wins.
        state_d.extPend = (state_q.extPend & ~extClr) | edgeHit;

        // Halt exit: which sources may leave which low power mode.
        unique case (powerMode)
            IPV_RUN: wakeCond = 1'b0;
            IPV_HALT: begin
                wakeCond = extReq[0] | lineOneRiseWake | extReq[2] | extReq[3];
            end
            IPV_TIMED_HALT: begin
                wakeCond = extReq[0] | lineOneRiseWake | extReq[2] | extReq[3] | extReq[4]
                    | periphReq[`IPV_PB_ATOVF] | periphReq[`IPV_PB_LTRTC];
            end
            IPV_AWU_HALT: begin
                wakeCond = extReq[0] | lineOneRiseWake | extReq[2] | extReq[3]
                    | periphReq[`IPV_PB_AWU];
            end
        endcase
        state_d.wakeUp = wakeCond;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q.pready <= 1'b0;
            state_q.pslverr <= 1'b0;
            state_q.prdata <= 32'h0000_0000;
            state_q.sense <= `IPV_SENSE_RESET;
            state_q.flag <= `IPV_FLAGS_RESET;
            state_q.enable <= `IPV_FLAGS_RESET;
            state_q.clrArm <= `IPV_FLAGS_RESET;
            state_q.extPend <= `IPV_FLAGS_RESET;
            state_q.extPrev <= 5'h1F;
            state_q.trapPend <= 1'b0;
            state_q.intReq <= 1'b0;
            state_q.isTrap <= 1'b0;
            state_q.slot <= 4'h0;
            state_q.vector <= `IPV_VEC_RESET;
            state_q.setMask <= 1'b0;
            state_q.wakeUp <= 1'b0;
        end else if (ce) begin
            state_q <= state_d;
        end
    end

    assign prdata = state_q.prdata;
    assign pready = state_q.pready;
    assign pslverr = state_q.pslverr;
    assign intReq = state_q.intReq;
    assign intVector = state_q.vector;
    assign setGlobalMask = state_q.setMask;
    assign wakeUp = state_q.wakeUp;

endmodule : ipv_ctrl

// *** tb/ipv_core_model.sv ***
// Behavioural core that acknowledges requests and keeps the global mask bit.
`timescale 1ns/10ps
module ipv_core_model (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic intReq,
    input wire logic setGlobalMask,
    input wire logic [3:0] ackWait,
    input wire logic maskCmd,
    input wire logic maskVal,
    output logic intAck,
    output logic globalMask
);
    logic [3:0] wait_q;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wait_q <= 4'h0;
            intAck <= 1'b0;
            globalMask <= 1'b1;
        end else begin
            wait_q <= (intReq && !intAck) ? wait_q + 4'h1 : 4'h0;
            intAck <= intReq && !intAck && wait_q == ackWait && ackWait != 4'hF;
            if (setGlobalMask) begin
                globalMask <= 1'b1;
            end else if (maskCmd) begin
                globalMask <= maskVal;
            end
        end
    end
endmodule : ipv_core_model

// *** tb/ipv_ctrl_assertions.sv ***
// Checker of the interrupt controller port behaviour.
`timescale 1ns/10ps
`include "ipv_map.svh"
module ipv_ctrl_checker (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic globalMask,
    input wire logic trapReq,
    input wire logic intAck,
    input wire logic intReq,
    input wire logic [15:0] intVector,
    input wire logic setGlobalMask,
    input wire logic wakeUp
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    a_pready_one_wait: assert property (psel && penable && !pready |=> pready)
        else $error("pready late");
    a_pready_single: assert property (pready |=> !pready)
        else $error("pready too long");
    a_unmapped_err: assert property (pready |-> pslverr == !(paddr inside
        {`IPV_ADDR_PSTAT, `IPV_ADDR_PEN, `IPV_ADDR_ASSOC, `IPV_ADDR_SENSE}))
        else $error("pslverr wrong");
    a_sense_width: assert property (
        pready && !pwrite && paddr == `IPV_ADDR_SENSE |-> prdata[31:8] == 24'h00_0000)
        else $error("sense upper bits set");
    a_req_unmasked: assert property (
        intReq && intVector != `IPV_VEC_TRAP |-> !$past(globalMask))
        else $error("request while masked");
    a_ack_masks: assert property (
        intReq && intAck |=> setGlobalMask && !intReq ##1 !setGlobalMask)
        else $error("ack not answered");
    a_vector_map: assert property (intReq |-> intVector inside {16'hFFFC, 16'hFFFA,
        16'hFFF8, 16'hFFF6, 16'hFFF4, 16'hFFF0, 16'hFFEE, 16'hFFEA, 16'hFFE8,
        16'hFFE6, 16'hFFE4}) else $error("vector outside map");
    a_reset_vector: assert property (
        $rose(reset_n) |-> intVector == `IPV_VEC_RESET && !intReq)
        else $error("reset vector wrong");
    a_trap_taken: assert property (
        trapReq && !intReq |=> ##[0:3] intReq && intVector == `IPV_VEC_TRAP)
        else $error("trap not presented");
    c_ack: cover property (intReq && intAck);
    c_wake: cover property (wakeUp);
    c_err: cover property (pready && pslverr);
endmodule : ipv_ctrl_checker
bind ipv_ctrl ipv_ctrl_checker i_ipv_ctrl_checker (.clk(clk), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .globalMask(globalMask), .trapReq(trapReq),
    .intAck(intAck), .intReq(intReq), .intVector(intVector),
    .setGlobalMask(setGlobalMask), .wakeUp(wakeUp));

// *** tb/ipv_tb.sv ***
// Self-checking bench of the interrupt controller.
`timescale 1ns/10ps
`include "ipv_map.svh"
module testbench
    import ipv_pkg::*;
;
    localparam logic [11:0] aSt = `IPV_ADDR_PSTAT;
    localparam logic [11:0] aEn = `IPV_ADDR_PEN;
    localparam logic [11:0] aSe = `IPV_ADDR_SENSE;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready;
    logic pslverr;
    logic [4:0] extLine = 5'h1F;
    logic [4:0] periphEvent = 5'h00;
    logic trapReq = 1'b0;
    ipv_power_type powerMode = IPV_RUN;
    logic intReq;
    logic [15:0] intVector;
    logic setGlobalMask;
    logic wakeUp;
    logic intAck;
    logic globalMask;
    logic w;
    logic err;
    logic [3:0] ackWait = 4'hF;
    logic maskCmd = 1'b0;
    logic maskVal = 1'b0;
    int bad_count = 0;
    int n_tests = 0;
    int cycles = 0;
    logic [15:0] pv [5] = '{16'hFFFA, 16'hFFEA, 16'hFFE8, 16'hFFE6, 16'hFFE4};
    always #25 clk = ~clk;
    ipv_ctrl #(.LINE_FOUR_SENSE(`IPV_SENSE_RISE)) i_ipv_ctrl (.clk(clk), .reset_n(reset_n),
        .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .extLine(extLine), .periphEvent(periphEvent), .globalMask(globalMask),
        .trapReq(trapReq), .intAck(intAck), .powerMode(powerMode), .intReq(intReq),
        .intVector(intVector), .setGlobalMask(setGlobalMask), .wakeUp(wakeUp));
    ipv_core_model i_ipv_core_model (.clk(clk), .reset_n(reset_n), .intReq(intReq),
        .setGlobalMask(setGlobalMask), .ackWait(ackWait), .maskCmd(maskCmd),
        .maskVal(maskVal), .intAck(intAck), .globalMask(globalMask));
    task automatic wrap_up;
        if (bad_count == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : wrap_up
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            wrap_up();
        end
    end
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", s, e, g);
            bad_count++;
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task automatic setMask(input logic v);
        @(posedge clk);
        maskCmd <= 1'b1;
        maskVal <= v;
        cyc(2);
        maskCmd <= 1'b0;
    endtask : setMask
    task automatic pulse(input logic [4:0] e);
        @(posedge clk);
        periphEvent <= e;
        @(posedge clk);
        periphEvent <= 5'h00;
    endtask : pulse
    task automatic waitHigh(ref logic s);
        while (s !== 1'b1) @(posedge clk);
    endtask : waitHigh
    task automatic watch(output logic seen);
        seen = 1'b0;
        repeat (8) begin
            @(posedge clk);
            seen = seen | wakeUp;
        end
    endtask : watch
    task automatic t_reset;
        chk("vector", 32'hFFFE, intVector);
        apb(1'b0, aSe, 32'h0);
        chk("sense", 32'h0, rd);
        chk("pslverr", 32'h0, err);
        apb(1'b0, 12'h040, 32'h0);
        chk("pslverr", 32'h1, err);
        chk("unmapped", 32'h0, rd);
        setMask(1'b1);
        apb(1'b1, aSe, 32'h3F);
        apb(1'b0, aSe, 32'h0);
        chk("sense", 32'h3F, rd);
        setMask(1'b0);
        apb(1'b1, aSe, 32'h0);
        apb(1'b0, aSe, 32'h0);
        chk("sense", 32'h3F, rd);
        setMask(1'b1);
        apb(1'b1, aSe, 32'h0);
        setMask(1'b0);
    endtask : t_reset
    task automatic t_periph;
        for (int i = 0; i < 5; i++) begin
            pulse(5'h01 << i);
            cyc(3);
            chk("intReq", 32'h0, intReq);
            apb(1'b0, aSt, 32'h0);
            chk("status", 32'h1 << i, rd);
            apb(1'b1, aEn, 32'h1 << i);
            waitHigh(intReq);
            chk("vector", pv[i], intVector);
            apb(1'b1, aSt, 32'h0);
            cyc(2);
            chk("intReq", 32'h0, intReq);
            apb(1'b1, aEn, 32'h0);
        end
        pulse(5'h04);
        apb(1'b0, aSt, 32'h0);
        apb(1'b0, `IPV_ADDR_ASSOC, 32'h0);
        apb(1'b0, aSt, 32'h0);
        chk("status", 32'h0, rd);
        apb(1'b1, aEn, 32'h04);
        cyc(4);
        chk("intReq", 32'h0, intReq);
    endtask : t_periph
    task automatic t_ack;
        apb(1'b1, aEn, 32'h1F);
        pulse(5'h1A);
        waitHigh(intReq);
        chk("vector", 32'hFFEA, intVector);
        ackWait <= 4'h2;
        waitHigh(setGlobalMask);
        cyc(2);
        chk("mask", 32'h1, globalMask);
        chk("intReq", 32'h0, intReq);
        apb(1'b1, aSt, 32'h0);
        apb(1'b1, aEn, 32'h0);
        @(posedge clk);
        trapReq <= 1'b1;
        ackWait <= 4'h0;
        @(posedge clk);
        trapReq <= 1'b0;
        waitHigh(intReq);
        chk("vector", 32'hFFFC, intVector);
        cyc(4);
        chk("intReq", 32'h0, intReq);
    endtask : t_ack
    task automatic t_ext;
        ackWait <= 4'hF;
        setMask(1'b0);
        extLine[0] <= 1'b0;
        waitHigh(intReq);
        chk("vector", 32'hFFF8, intVector);
        extLine[0] <= 1'b1;
        ackWait <= 4'h0;
        waitHigh(setGlobalMask);
        ackWait <= 4'hF;
        cyc(6);
        setMask(1'b0);
        cyc(4);
        chk("intReq", 32'h0, intReq);
        for (int c = 1; c < 4; c++) begin
            for (int h = 0; h < 2; h++) begin
                setMask(1'b1);
                apb(1'b1, aSe, 32'h0);
                apb(1'b1, aSe, c << 4);
                setMask(1'b0);
                cyc(4);
                chk("intReq", 32'h0, intReq);
                extLine[2] <= h[0];
                cyc(6);
                chk("intReq", c[1 - h], intReq);
            end
        end
        setMask(1'b1);
        apb(1'b1, aSe, 32'h0C);
    endtask : t_ext
    task automatic t_wake;
        apb(1'b1, aEn, 32'h05);
        powerMode <= IPV_HALT;
        pulse(5'h04);
        watch(w);
        chk("wakeUp", 32'h0, w);
        powerMode <= IPV_TIMED_HALT;
        watch(w);
        chk("wakeUp", 32'h1, w);
        apb(1'b1, aSt, 32'h0);
        pulse(5'h01);
        watch(w);
        chk("wakeUp", 32'h0, w);
        powerMode <= IPV_AWU_HALT;
        watch(w);
        chk("wakeUp", 32'h1, w);
        apb(1'b1, aSt, 32'h0);
        cyc(2);
        powerMode <= IPV_HALT;
        extLine[1] <= 1'b0;
        watch(w);
        chk("wakeUp", 32'h0, w);
        extLine[1] <= 1'b1;
        watch(w);
        chk("wakeUp", 32'h1, w);
    endtask : t_wake
    initial begin
        cyc(8);
        reset_n <= 1'b1;
        cyc(3);
        t_reset();
        t_periph();
        t_ack();
        t_ext();
        t_wake();
        wrap_up();
    end
endmodule : testbench
